// ==== core/flash_prog_pkg.sv ====
package flash_prog_pkg;

  // ****************************************************************
  // Clock and programming times
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS   = 50;
  localparam int unsigned ERASE_TIME_US   = 5000;
  localparam int unsigned WRITE_TIME_US   = 5000;
  localparam int unsigned ERASE_CYCLES    = (ERASE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WRITE_CYCLES    = (WRITE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TIMER_WIDTH     = 24;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [11:0] FLASH_CTRL_OFFSET = 12'h000;
  localparam logic [11:0] AUX_ONE_OFFSET    = 12'h004;
  localparam logic [11:0] AUX_ZERO_OFFSET   = 12'h008;

  // ****************************************************************
  // Field layout
  // ****************************************************************
  localparam int unsigned KEY_MSB        = 7;
  localparam int unsigned KEY_LSB        = 4;
  localparam int unsigned LATCH_MAP_BIT  = 3;
  localparam int unsigned SPACE_MSB      = 2;
  localparam int unsigned SPACE_LSB      = 1;
  localparam int unsigned BUSY_BIT       = 0;
  localparam int unsigned BOOT_MAP_BIT   = 5;
  localparam int unsigned XRAM_SEL_BIT   = 1;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  localparam logic [3:0]  KEY_UNLOCK     = 4'h5;
  localparam logic [3:0]  KEY_LAUNCH     = 4'hA;

  // ****************************************************************
  // Array geometry
  // ****************************************************************
  localparam int unsigned PAGE_BYTES     = 128;
  localparam int unsigned OFFSET_BITS    = 7;
  localparam int unsigned PAGE_BITS      = 8;
  localparam int unsigned NUM_PAGES      = 256;
  localparam logic [15:0] EXTRA_ROW_BASE = 16'hFF80;
  localparam logic [15:0] BOOT_BASE      = 16'hF800;
  localparam logic [15:0] SECURITY_ADDR  = 16'h0000;
  localparam logic [7:0]  ERASED_BYTE    = 8'hFF;
  localparam logic [7:0]  SECURITY_RESET = 8'hFF;
  localparam logic [3:0]  NIBBLE_ERASED  = 4'hF;

  typedef enum logic [1:0] {
    SPACE_USER     = 2'b00,
    SPACE_EXTRA    = 2'b01,
    SPACE_SECURITY = 2'b10,
    SPACE_RESERVED = 2'b11
  } space_t;

endpackage

// ==== core/cycle_timer.sv ====
`timescale 1ns/1ns
module cycle_timer #(
  parameter int unsigned WIDTH = 24
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             start,
  input  wire logic [WIDTH-1:0] load_value,
  output logic                  running,
  output logic                  done
);

  logic [WIDTH-1:0] remaining;
  wire              last_tick = running && (remaining == WIDTH'(1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remaining <= '0;
      running   <= 1'b0;
      done      <= 1'b0;
    end else begin
      done <= last_tick;
      if (start) begin
        remaining <= load_value;
        running   <= 1'b1;
      end else if (running) begin
        remaining <= remaining - WIDTH'(1);
        running   <= !last_tick;
      end
    end
  end

endmodule // cycle_timer

// ==== core/column_latch_buffer.sv ====
`timescale 1ns/1ns
module column_latch_buffer #(
  parameter int unsigned BYTES = 128,
  parameter int unsigned IDX_W = 7
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             load,
  input  wire logic [IDX_W-1:0] load_index,
  input  wire logic [7:0]       load_data,
  input  wire logic             clear,
  output logic [7:0]            data [BYTES],
  output logic [BYTES-1:0]      loaded
);

  // Clear wins only over stale marks: a load in the same cycle survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded <= '0;
    end else begin
      for (int i = 0; i < BYTES; i++) begin
        if (load && (load_index == IDX_W'(i))) begin
          loaded[i] <= 1'b1;
        end else if (clear) begin
          loaded[i] <= 1'b0;
        end
      end
    end
  end

  always_ff @(posedge pclk) begin
    if (load) begin
      data[load_index] <= load_data;
    end
  end

endmodule // column_latch_buffer

// ==== core/flash_page_program_control.sv ====
`timescale 1ns/1ns
// Operation
// - 128-byte column latch is sole write entry
// - Array read-only until latch map bit set
// - Write address 6:0 byte, 14:7 page
// - Latch map overrides external RAM select
// - Space select maps user, extra row, security
// - Key 5 then A launches programming
// - Launch target follows space select; reserved idle
// - Busy at launch, fetches withheld meanwhile
// - Core held idle, released at completion
// - Busy bit reads one throughout programming
// - Boot map bit selects boot array upward
// - Only loaded bytes erased then programmed
// - Last latch write page selects target
// - Security upper nibble software, lower parallel
// - Extra row is one separate page
// - Control layout key, map, space, busy
// - Boot array from F800h when mapped
module flash_page_program_control #(
  parameter int unsigned NUM_PAGES    = flash_prog_pkg::NUM_PAGES,
  parameter int unsigned ERASE_CYCLES = flash_prog_pkg::ERASE_CYCLES,
  parameter int unsigned WRITE_CYCLES = flash_prog_pkg::WRITE_CYCLES
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB register port
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // Core code reads
  input  wire logic        code_rd,
  input  wire logic [15:0] code_addr,
  output logic [7:0]       code_data,
  output logic             code_valid,
  // Core data-space writes
  input  wire logic        data_wr,
  input  wire logic [15:0] data_addr,
  input  wire logic [7:0]  data_wdata,
  output logic             eram_wr,
  output logic             xram_wr,
  output logic [15:0]      xdata_addr,
  output logic [7:0]       xdata_wdata,
  // Boot array, read combinationally
  output logic [15:0]      boot_addr,
  input  wire logic [7:0]  boot_data,
  // Parallel programming of the security low nibble
  input  wire logic        par_nibble_wr,
  input  wire logic [3:0]  par_nibble_data,
  // Status to the core
  output logic             program_in_progress,
  output logic             core_idle_hold
);

  // ****************************************************************
  // Storage
  // ****************************************************************
  localparam int unsigned ADDR_W = flash_prog_pkg::OFFSET_BITS + $clog2(NUM_PAGES);

  logic [7:0] main_flash_array [NUM_PAGES * flash_prog_pkg::PAGE_BYTES];
  logic [7:0] extra_row_page   [flash_prog_pkg::PAGE_BYTES];
  logic [7:0] security_byte;

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [3:0] launch_key_field;
  logic       latch_map_select;
  logic [1:0] space_select_field;
  logic       boot_array_map;
  logic       external_ram_select;
  logic       unlock_armed;
  logic [flash_prog_pkg::PAGE_BITS-1:0] target_page;
  flash_prog_pkg::space_t op_space;

  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_WRITE} seq_state_t;
  seq_state_t state;
  seq_state_t next_state;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire setup_phase = psel && !penable;
  wire access_wr   = psel && penable && pwrite;
  wire hit_ctrl    = (paddr == flash_prog_pkg::FLASH_CTRL_OFFSET);
  wire hit_aux1    = (paddr == flash_prog_pkg::AUX_ONE_OFFSET);
  wire hit_aux0    = (paddr == flash_prog_pkg::AUX_ZERO_OFFSET);
  wire hit_any     = hit_ctrl || hit_aux1 || hit_aux0;
  wire lane0       = pstrb[0];
  wire ctrl_wr     = access_wr && hit_ctrl && lane0;
  wire aux1_wr     = access_wr && hit_aux1 && lane0;
  wire aux0_wr     = access_wr && hit_aux0 && lane0;
  wire [3:0] key_in = pwdata[flash_prog_pkg::KEY_MSB:flash_prog_pkg::KEY_LSB];

  wire busy = (state != ST_IDLE);

  wire [7:0] ctrl_view = {launch_key_field, latch_map_select, space_select_field, busy};
  wire [7:0] aux1_view = 8'(boot_array_map) << flash_prog_pkg::BOOT_MAP_BIT;
  wire [7:0] aux0_view = 8'(external_ram_select) << flash_prog_pkg::XRAM_SEL_BIT;
  wire [7:0] read_mux  = hit_ctrl ? ctrl_view : (hit_aux1 ? aux1_view : (hit_aux0 ? aux0_view : 8'h00));

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit_any;

  // Read data is captured in setup so the access phase needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup_phase) begin
      prdata <= {24'h00_0000, read_mux};
    end
  end

  // ****************************************************************
  // Launch key
  // ****************************************************************
  // Arm only on a 5, and any other control write disarms
  wire launch_hit = ctrl_wr && unlock_armed && (key_in == flash_prog_pkg::KEY_LAUNCH);
  wire [1:0] space_in = pwdata[flash_prog_pkg::SPACE_MSB:flash_prog_pkg::SPACE_LSB];
  wire launch = launch_hit && !busy &&
                (flash_prog_pkg::space_t'(space_in) != flash_prog_pkg::SPACE_RESERVED);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      unlock_armed <= 1'b0;
    end else if (ctrl_wr) begin
      unlock_armed <= (key_in == flash_prog_pkg::KEY_UNLOCK) && !busy;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      launch_key_field   <= flash_prog_pkg::CTRL_RESET[flash_prog_pkg::KEY_MSB:flash_prog_pkg::KEY_LSB];
      latch_map_select   <= flash_prog_pkg::CTRL_RESET[flash_prog_pkg::LATCH_MAP_BIT];
      space_select_field <= flash_prog_pkg::CTRL_RESET[flash_prog_pkg::SPACE_MSB:flash_prog_pkg::SPACE_LSB];
    end else if (ctrl_wr) begin
      launch_key_field   <= key_in;
      latch_map_select   <= pwdata[flash_prog_pkg::LATCH_MAP_BIT];
      space_select_field <= space_in;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      boot_array_map      <= 1'b0;
      external_ram_select <= 1'b0;
    end else begin
      if (aux1_wr) begin
        boot_array_map <= pwdata[flash_prog_pkg::BOOT_MAP_BIT];
      end
      if (aux0_wr) begin
        external_ram_select <= pwdata[flash_prog_pkg::XRAM_SEL_BIT];
      end
    end
  end

  // ****************************************************************
  // Data-space writes
  // ****************************************************************
  // Latch writes are refused while busy so the page cannot change under the sequencer
  wire latch_wr = data_wr && latch_map_select && !busy;
  wire [flash_prog_pkg::OFFSET_BITS-1:0] byte_sel = data_addr[flash_prog_pkg::OFFSET_BITS-1:0];
  wire [flash_prog_pkg::PAGE_BITS-1:0] page_sel =
    data_addr[flash_prog_pkg::OFFSET_BITS+flash_prog_pkg::PAGE_BITS-1:flash_prog_pkg::OFFSET_BITS];
  wire fwd_wr = data_wr && !latch_map_select;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eram_wr     <= 1'b0;
      xram_wr     <= 1'b0;
      xdata_addr  <= 16'h0000;
      xdata_wdata <= 8'h00;
      target_page <= '0;
    end else begin
      eram_wr <= fwd_wr && !external_ram_select;
      xram_wr <= fwd_wr && external_ram_select;
      if (fwd_wr) begin
        xdata_addr  <= data_addr;
        xdata_wdata <= data_wdata;
      end
      if (latch_wr) begin
        target_page <= page_sel;
      end
    end
  end

  // ****************************************************************
  // Column latches and timer
  // ****************************************************************
  logic [7:0]                            latch_data [flash_prog_pkg::PAGE_BYTES];
  logic [flash_prog_pkg::PAGE_BYTES-1:0] latch_loaded;
  logic                                  erase_done;
  logic                                  write_done;
  logic                                  timer_done;

  wire finish = (state == ST_WRITE) && timer_done;

  column_latch_buffer #(
    .BYTES (flash_prog_pkg::PAGE_BYTES),
    .IDX_W (flash_prog_pkg::OFFSET_BITS)
  ) u_latch (
    .pclk       (pclk),
    .presetn    (presetn),
    .load       (latch_wr),
    .load_index (byte_sel),
    .load_data  (data_wdata),
    .clear      (finish),
    .data       (latch_data),
    .loaded     (latch_loaded)
  );

  wire timer_start = launch || ((state == ST_ERASE) && timer_done);
  wire [flash_prog_pkg::TIMER_WIDTH-1:0] timer_load =
    launch ? flash_prog_pkg::TIMER_WIDTH'(ERASE_CYCLES) : flash_prog_pkg::TIMER_WIDTH'(WRITE_CYCLES);

  cycle_timer #(
    .WIDTH (flash_prog_pkg::TIMER_WIDTH)
  ) u_timer (
    .pclk       (pclk),
    .presetn    (presetn),
    .start      (timer_start),
    .load_value (timer_load),
    .running    (),
    .done       (timer_done)
  );

  // ****************************************************************
  // Erase-then-program sequencer
  // ****************************************************************
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE:  if (launch) next_state = ST_ERASE;
      ST_ERASE: if (timer_done) next_state = ST_WRITE;
      ST_WRITE: if (timer_done) next_state = ST_IDLE;
      default:  next_state = ST_IDLE;
    endcase
  end

  assign erase_done = (state == ST_ERASE) && timer_done;
  assign write_done = finish;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state    <= ST_IDLE;
      op_space <= flash_prog_pkg::SPACE_USER;
    end else begin
      state <= next_state;
      if (launch) begin
        op_space <= flash_prog_pkg::space_t'(space_in);
      end
    end
  end

  assign program_in_progress = busy;
  assign core_idle_hold      = busy;

  // ****************************************************************
  // Array updates
  // ****************************************************************
  wire do_user  = (op_space == flash_prog_pkg::SPACE_USER);
  wire do_extra = (op_space == flash_prog_pkg::SPACE_EXTRA);
  wire do_fuse  = (op_space == flash_prog_pkg::SPACE_SECURITY);
  wire [ADDR_W-1:0] page_base = {ADDR_W'(target_page)} << flash_prog_pkg::OFFSET_BITS;

  // Flash content survives reset, so the arrays have none
  always_ff @(posedge pclk) begin
    for (int i = 0; i < flash_prog_pkg::PAGE_BYTES; i++) begin
      if (latch_loaded[i] && (erase_done || write_done)) begin
        if (do_user) begin
          main_flash_array[page_base + ADDR_W'(i)] <= erase_done ? flash_prog_pkg::ERASED_BYTE : latch_data[i];
        end
        if (do_extra) begin
          extra_row_page[i] <= erase_done ? flash_prog_pkg::ERASED_BYTE : latch_data[i];
        end
      end
    end
  end

  // Only the upper nibble follows software; the lower one is parallel-only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      security_byte <= flash_prog_pkg::SECURITY_RESET;
    end else begin
      if (do_fuse && latch_loaded[0] && erase_done) begin
        security_byte[7:4] <= flash_prog_pkg::NIBBLE_ERASED;
      end else if (do_fuse && latch_loaded[0] && write_done) begin
        security_byte[7:4] <= latch_data[0][7:4];
      end
      if (par_nibble_wr) begin
        security_byte[3:0] <= par_nibble_data;
      end
    end
  end

  // ****************************************************************
  // Code reads
  // ****************************************************************
  wire in_boot  = boot_array_map && (code_addr >= flash_prog_pkg::BOOT_BASE);
  wire in_extra = (code_addr >= flash_prog_pkg::EXTRA_ROW_BASE);
  wire [ADDR_W-1:0] user_idx = code_addr[ADDR_W-1:0];
  wire [flash_prog_pkg::OFFSET_BITS-1:0] row_idx = code_addr[flash_prog_pkg::OFFSET_BITS-1:0];

  logic [7:0] space_data;
  always_comb begin
    space_data = flash_prog_pkg::ERASED_BYTE;
    unique case (flash_prog_pkg::space_t'(space_select_field))
      flash_prog_pkg::SPACE_USER:     space_data = main_flash_array[user_idx];
      flash_prog_pkg::SPACE_EXTRA:    if (in_extra) space_data = extra_row_page[row_idx];
      flash_prog_pkg::SPACE_SECURITY: if (code_addr == flash_prog_pkg::SECURITY_ADDR) space_data = security_byte;
      flash_prog_pkg::SPACE_RESERVED: space_data = flash_prog_pkg::ERASED_BYTE;
    endcase
  end

  assign boot_addr = code_addr;
  wire [7:0] fetch_data = in_boot ? boot_data : space_data;
  wire fetch_ok = code_rd && !busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      code_data  <= 8'h00;
      code_valid <= 1'b0;
    end else begin
      code_valid <= fetch_ok;
      if (fetch_ok) begin
        code_data <= fetch_data;
      end
    end
  end

endmodule // flash_page_program_control

// ==== dv/flash_prog_assertions.sv ====
`timescale 1ns/1ns
module flash_prog_assertions #(
  parameter int unsigned ERASE_CYCLES = 4,
  parameter int unsigned WRITE_CYCLES = 6
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        code_rd,
  input wire logic [15:0] code_addr,
  input wire logic [7:0]  code_data,
  input wire logic        code_valid,
  input wire logic        data_wr,
  input wire logic        eram_wr,
  input wire logic        xram_wr,
  input wire logic [15:0] boot_addr,
  input wire logic [7:0]  boot_data,
  input wire logic        program_in_progress,
  input wire logic        core_idle_hold
);
  // ****************************************
  // Shadow of the control state
  // ****************************************
  localparam int BMIN = ERASE_CYCLES + WRITE_CYCLES - 1;
  localparam int BMAX = ERASE_CYCLES + WRITE_CYCLES + 4;
  logic armed;
  logic map_on;
  logic boot_on;
  wire  acc     = psel && penable;
  wire  wr_ok   = acc && pwrite && pstrb[0];
  wire  ctrl_wr = wr_ok && paddr == 12'h000;
  wire  launch  = ctrl_wr && armed && pwdata[7:4] == 4'hA && pwdata[2:1] != 2'b11 && !program_in_progress;

  // Any control write re-arms or disarms, so a broken key pair never launches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      armed   <= 1'b0;
      map_on  <= 1'b0;
      boot_on <= 1'b0;
    end else begin
      if (ctrl_wr) begin
        armed  <= pwdata[7:4] == 4'h5 && !program_in_progress;
        map_on <= pwdata[3];
      end
      if (wr_ok && paddr == 12'h004) begin
        boot_on <= pwdata[5];
      end
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_slverr_decode: assert property (acc |-> pslverr == !(paddr inside {12'h000, 12'h004, 12'h008}))
    else $error("slave error does not match address decode");
  a_launch_busy: assert property (launch |=> program_in_progress)
    else $error("key pair did not start programming");
  a_broken_key: assert property (ctrl_wr && !armed && !program_in_progress |=> !program_in_progress)
    else $error("programming started without an armed key");
  a_busy_span: assert property ($rose(program_in_progress) |-> ##[BMIN:BMAX] $fell(program_in_progress))
    else $error("busy span out of range");
  a_busy_read: assert property (acc && !pwrite && paddr == 12'h000 |-> prdata[0] == $past(program_in_progress))
    else $error("busy bit read back wrong");
  a_no_fetch_busy: assert property (program_in_progress |=> !code_valid)
    else $error("fetch answered while busy");
  a_fetch_answer: assert property (code_rd && !program_in_progress |=> code_valid)
    else $error("fetch not answered");
  a_idle_follow: assert property (core_idle_hold == program_in_progress)
    else $error("core hold differs from busy");
  a_boot_select: assert property (code_rd && !program_in_progress && boot_on && code_addr >= 16'hF800
    |=> code_valid && code_data == $past(boot_data) && $past(boot_addr) == $past(code_addr))
    else $error("boot array not selected");
  a_latch_override: assert property (data_wr && map_on |=> !eram_wr && !xram_wr)
    else $error("latch write leaked to data space");
  a_write_forward: assert property (data_wr && !map_on |=> eram_wr != xram_wr)
    else $error("data write not forwarded once");

  cover property (launch);
  cover property ($fell(program_in_progress));
  cover property (code_valid && boot_on);
endmodule // flash_prog_assertions

bind flash_page_program_control flash_prog_assertions #(
  .ERASE_CYCLES(ERASE_CYCLES),
  .WRITE_CYCLES(WRITE_CYCLES)
) i_flash_prog_assertions (.*);

// ==== dv/core_model.sv ====
`timescale 1ns/1ns
module core_model (
  input  wire logic        pclk,
  output logic             code_rd,
  output logic [15:0]      code_addr,
  input  wire logic [7:0]  code_data,
  input  wire logic        code_valid,
  output logic             data_wr,
  output logic [15:0]      data_addr,
  output logic [7:0]       data_wdata,
  input  wire logic [15:0] boot_addr,
  output logic [7:0]       boot_data
);
  // Boot array stand-in: low address byte XOR C3h, so F800h reads C3h rather than the programmed 3Ch
  assign boot_data = boot_addr[7:0] ^ 8'hC3;

  initial begin
    code_rd    = 1'b0;
    code_addr  = 16'h0000;
    data_wr    = 1'b0;
    data_addr  = 16'h0000;
    data_wdata = 8'h00;
  end

  // One attempt only: the core has no interrupt source, so nothing retries early
  task automatic fetch(input logic [15:0] a, output logic [7:0] d, output logic ok);
    @(posedge pclk);
    code_rd   <= 1'b1;
    code_addr <= a;
    @(posedge pclk);
    code_rd   <= 1'b0;
    code_addr <= ~a;
    #1;
    ok = code_valid;
    d  = code_data;
  endtask

  task automatic store(input logic [15:0] a, input logic [7:0] d);
    @(posedge pclk);
    data_wr    <= 1'b1;
    data_addr  <= a;
    data_wdata <= d;
    @(posedge pclk);
    data_wr    <= 1'b0;
    data_addr  <= ~a;
    data_wdata <= ~d;
  endtask
endmodule // core_model

// ==== dv/tb_top.sv ====
`timescale 1ns/1ns
module tb_top;
  localparam int unsigned EC = 4;
  localparam int unsigned WC = 6;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0]  pstrb = 4'hF;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, code_rd, code_valid, data_wr, eram_wr, xram_wr, ok, err;
  logic [15:0] code_addr, data_addr, xdata_addr, boot_addr;
  logic [7:0]  code_data, data_wdata, xdata_wdata, boot_data, fd;
  logic        par_nibble_wr = 1'b0;
  logic [3:0]  par_nibble_data = 4'h0;
  logic        program_in_progress, core_idle_hold;
  int          n_errors = 0;
  int          samples_checked = 0;

  always #25 pclk = ~pclk;

  flash_page_program_control #(.ERASE_CYCLES(EC), .WRITE_CYCLES(WC)) i_flash_page_program_control (.*);
  core_model i_core_model (.*);

  // ****************************************
  // Bus and compare helpers
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic ctl(input logic [7:0] v);
    apb(1'b1, 12'h000, {24'h000000, v});
  endtask

  task automatic fetch_chk(input logic [15:0] a, input logic [7:0] exp);
    i_core_model.fetch(a, fd, ok);
    chk({31'h0, ok}, 32'h1);
    chk({24'h0, fd}, {24'h0, exp});
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, 12'h000, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 40);
    chk({31'h0, rd[0]}, 32'h0);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset;
    apb(1'b0, 12'h000, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 12'h00C, 32'h0);
    chk({31'h0, err}, 32'h1);
  endtask

  task automatic t_user_program;
    ctl(8'h08);
    i_core_model.store(16'h0185, 8'hA5);
    i_core_model.store(16'h7800, 8'h3C);
    ctl(8'h50);
    ctl(8'hA0);
    apb(1'b0, 12'h000, 32'h0);
    chk({31'h0, rd[0]}, 32'h1);
    chk({31'h0, core_idle_hold}, 32'h1);
    i_core_model.fetch(16'h0000, fd, ok);
    chk({31'h0, ok}, 32'h0);
    wait_idle;
    chk({31'h0, core_idle_hold}, 32'h0);
    ctl(8'h00);
    fetch_chk(16'hF800, 8'h3C);
    fetch_chk(16'hF805, 8'hA5);
    apb(1'b1, 12'h004, 32'h20);
    fetch_chk(16'hF800, 8'hC3);
    apb(1'b1, 12'h004, 32'h0);
  endtask

  task automatic t_partial_page;
    ctl(8'h08);
    i_core_model.store(16'h0200, 8'h11);
    ctl(8'h58);
    ctl(8'hA8);
    wait_idle;
    ctl(8'h00);
    fetch_chk(16'h0200, 8'h11);
    fetch_chk(16'h0205, 8'hxx);
    fetch_chk(16'hF800, 8'h3C);
  endtask

  task automatic t_key_refused;
    ctl(8'h58);
    ctl(8'h08);
    ctl(8'hA8);
    apb(1'b0, 12'h000, 32'h0);
    chk({31'h0, rd[0]}, 32'h0);
    ctl(8'h5E);
    ctl(8'hAE);
    apb(1'b0, 12'h000, 32'h0);
    chk({31'h0, rd[0]}, 32'h0);
  endtask

  task automatic t_extra_row;
    ctl(8'h08);
    i_core_model.store(16'hFF82, 8'h77);
    ctl(8'h52);
    ctl(8'hA2);
    wait_idle;
    ctl(8'h02);
    fetch_chk(16'hFF82, 8'h77);
  endtask

  task automatic t_security;
    ctl(8'h0C);
    i_core_model.store(16'h0000, 8'h5A);
    ctl(8'h54);
    ctl(8'hA4);
    wait_idle;
    ctl(8'h04);
    fetch_chk(16'h0000, 8'h5F);
    @(posedge pclk);
    par_nibble_wr   <= 1'b1;
    par_nibble_data <= 4'h3;
    @(posedge pclk);
    par_nibble_wr   <= 1'b0;
    fetch_chk(16'h0000, 8'h53);
    ctl(8'h00);
  endtask

  task automatic t_forward;
    apb(1'b1, 12'h008, 32'h2);
    apb(1'b0, 12'h008, 32'h0);
    chk(rd, 32'h2);
    i_core_model.store(16'h1234, 8'h99);
    #1;
    chk({6'h00, xram_wr, eram_wr, xdata_addr, xdata_wdata}, {6'h00, 1'h1, 1'h0, 16'h1234, 8'h99});
    apb(1'b1, 12'h008, 32'h0);
    i_core_model.store(16'h1235, 8'h98);
    #1;
    chk({6'h00, xram_wr, eram_wr, xdata_addr, xdata_wdata}, {6'h00, 1'h0, 1'h1, 16'h1235, 8'h98});
  endtask

  task automatic end_of_test;
    $display("errors %0d, checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_user_program;
    t_partial_page;
    t_key_refused;
    t_extra_row;
    t_security;
    t_forward;
    end_of_test;
  end

  // Whole run is under two hundred cycles; the 4000-cycle limit leaves ample margin
  initial begin
    #(50 * 4000);
    n_errors++;
    end_of_test;
  end
endmodule // tb_top
